// file: fpep_guard.sv
`timescale 1ns/1ns
module fpep_guard
	import fpep_pkg::*;
(
	// Decision signals
	fpep_if.guard pi
);
	logic blocks_none;
	logic emul_prot;

	// Software protection terms
	assign blocks_none = (pi.block_sel == 16'h0000); // see RULE_02
	assign emul_prot = pi.ovl_hi ^ pi.ovl_lo; // see RULE_04
	assign pi.sw_prot = blocks_none | emul_prot; // see RULE_01

	// Request gated by every protection in force
	assign pi.program_en = pi.program_req & ~pi.sw_prot & ~pi.hw_block & ~pi.int_prot; // see RULE_20
	assign pi.erase_en = pi.erase_req & ~pi.sw_prot & ~pi.hw_block & ~pi.int_prot; // see RULE_20

	// Emulation, hardware and interrupt protection stop all blocks together, else the selection applies
	assign pi.block_en = (emul_prot | pi.hw_block | pi.int_prot) ? 16'h0000 : pi.block_sel; // see RULE_04

	// Verify survives software and interrupt protection, not hardware clears
	assign pi.verify_en = pi.hw_block ? 3'h0 : pi.verify_req; // see RULE_03
endmodule

// file: fpep_if.sv
`timescale 1ns/1ns
interface fpep_if;
	// Protection decision group
	logic program_req;
	logic erase_req;
	logic [2:0] verify_req;
	logic [15:0] block_sel;
	logic ovl_hi;
	logic ovl_lo;
	logic hw_block;
	logic int_prot;
	logic program_en;
	logic erase_en;
	logic [2:0] verify_en;
	logic [15:0] block_en;
	logic sw_prot;
	// Overlap mapping group
	logic [15:0] cpu_addr;
	logic ovl_live;
	logic ram_hit;
	logic [15:0] ram_addr;
	modport main (output program_req, erase_req, verify_req, block_sel, ovl_hi, ovl_lo,
		hw_block, int_prot, cpu_addr, ovl_live,
		input program_en, erase_en, verify_en, block_en, sw_prot, ram_hit, ram_addr);
	modport guard (input program_req, erase_req, verify_req, block_sel, ovl_hi, ovl_lo,
		hw_block, int_prot, output program_en, erase_en, verify_en, block_en, sw_prot);
	modport ovl (input ovl_hi, ovl_lo, cpu_addr, ovl_live, output ram_hit, ram_addr);
endinterface

// file: fpep_overlap.sv
`timescale 1ns/1ns
module fpep_overlap
	import fpep_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Mapping signals
	fpep_if.ovl oi
);
	logic ram_hit_d;
	logic ram_hit_q;
	logic [15:0] ram_addr_d;
	logic [15:0] ram_addr_q;

	// Flash address to overlapping RAM address by select bits
	always_comb
	begin
		ram_hit_d = 1'b0;
		ram_addr_d = 16'h0000;
		case ({oi.ovl_hi, oi.ovl_lo})
			2'b01:
			begin
				ram_hit_d = (oi.cpu_addr >= FPEP_ROM_LO_01) && (oi.cpu_addr <= FPEP_ROM_HI_01);
				ram_addr_d = FPEP_RAM_BASE_B + (oi.cpu_addr - FPEP_ROM_LO_01);
			end
			2'b10:
			begin
				ram_hit_d = (oi.cpu_addr >= FPEP_ROM_LO_01) && (oi.cpu_addr <= FPEP_ROM_HI_10);
				ram_addr_d = FPEP_RAM_BASE_B + (oi.cpu_addr - FPEP_ROM_LO_01);
			end
			2'b11:
			begin
				ram_hit_d = oi.ovl_live && (oi.cpu_addr <= FPEP_ROM_LIMIT_11); // see RULE_13
				ram_addr_d = FPEP_RAM_BASE_A + oi.cpu_addr;
			end
			default:
			begin
				ram_hit_d = 1'b0;
				ram_addr_d = 16'h0000;
			end
		endcase
	end

	// Registered result; RAM hits bypass emulation protection
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ram_hit_q <= 1'b0;
			ram_addr_q <= 16'h0000;
		end
		else
		begin
			ram_hit_q <= ram_hit_d; // see RULE_05
			ram_addr_q <= ram_addr_d;
		end
	end

	assign oi.ram_hit = ram_hit_q;
	assign oi.ram_addr = ram_addr_q;
endmodule

// file: fpep_pkg.sv
// Summary of operation
// RULE_01 - Software protection blocks program and erase even with program or erase bit set.
// RULE_02 - Only selected blocks may be altered; both select registers zero protects all.
// RULE_03 - Block and emulation protection still allow all three verify modes.
// RULE_04 - Exactly one overlap select bit set protects every block, erase for all at once.
// RULE_05 - RAM currently overlapped onto flash is not covered by emulation protection.
// RULE_06 - Hardware protection stops program and erase and clears control and select registers.
// RULE_07 - Without 12 V, registers stay cleared and program, erase and verify are off. The wait configuration register is kept here.
// RULE_08 - Any reset, watchdog included, or standby clears registers and disables all modes. Standby here keeps wait configuration and interrupt protection.
// RULE_09 - Outside party holds reset 20 ms at power-up, ten clocks in operation.
// RULE_10 - Interrupt during program or erase aborts at once, keeps registers, verify allowed.
// RULE_11 - After interrupt protection, program and erase stay off until a reset.
// RULE_12 - Flash reads while program or erase bit is set are marked invalid.
// RULE_13 - Both overlap bits, 12 V and an interrupt map RAM F800-F87F onto flash 0000-007F.
// RULE_14 - Software puts the interrupt vector at RAM F806 and then sets both overlap bits.
// RULE_15 - The non-maskable handler lies outside flash in modes 2 and 3.
// RULE_16 - Interrupt mask bit at 1 masks every source except the non-maskable one.
// RULE_17 - Boot mode sets both overlap bits and accepts only the non-maskable interrupt.
// RULE_18 - A boot user program without interrupts clears both overlap bits itself.
// RULE_19 - Overlap select bits are bits 7 and 6 of the wait configuration register.
// RULE_20 - Program and erase enables are the requests gated by every active protection.
package fpep_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] FPEP_OFS_FLASH_CTRL = 4'h0;
	localparam logic [3:0] FPEP_OFS_BLOCK_SEL_A = 4'h1;
	localparam logic [3:0] FPEP_OFS_BLOCK_SEL_B = 4'h2;
	localparam logic [3:0] FPEP_OFS_WAIT_CONFIG = 4'h3;
	localparam logic [3:0] FPEP_OFS_STATUS = 4'h4;
	// Flash control fields
	localparam int FPEP_FC_PROGRAM = 0;
	localparam int FPEP_FC_ERASE = 1;
	localparam int FPEP_FC_PROG_VFY = 2;
	localparam int FPEP_FC_ERASE_VFY = 3;
	localparam int FPEP_FC_PREW_VFY = 4;
	// Wait configuration fields
	localparam int FPEP_WC_OVL_HI = 7;
	localparam int FPEP_WC_OVL_LO = 6;
	// Status fields
	localparam int FPEP_ST_SW_PROT = 0;
	localparam int FPEP_ST_INT_PROT = 1;
	localparam int FPEP_ST_VPP_OK = 2;
	localparam int FPEP_ST_OVL_LIVE = 3;
	localparam int FPEP_ST_RD_VALID = 4;
	localparam int FPEP_ST_BOOT = 5;
	// Reset values
	localparam logic [7:0] FPEP_RST_FLASH_CTRL = 8'h00;
	localparam logic [7:0] FPEP_RST_BLOCK_SEL = 8'h00;
	localparam logic [7:0] FPEP_RST_WAIT_CONFIG = 8'h08;
	// Overlap address windows
	localparam logic [15:0] FPEP_RAM_BASE_A = 16'hf800;
	localparam logic [15:0] FPEP_RAM_BASE_B = 16'hf880;
	localparam logic [15:0] FPEP_ROM_LIMIT_11 = 16'h007f;
	localparam logic [15:0] FPEP_ROM_LO_01 = 16'h0080;
	localparam logic [15:0] FPEP_ROM_HI_01 = 16'h00ff;
	localparam logic [15:0] FPEP_ROM_HI_10 = 16'h017f;
	// Least reset hold during operation in system clocks, and at power-up in ms and in clocks
	localparam int FPEP_RST_RUN_CYC = 10;
	localparam int FPEP_RST_PWRUP_MS = 20;
	localparam int FPEP_CLK_MHZ = 50;
	localparam int FPEP_RST_PWRUP_CYC = FPEP_RST_PWRUP_MS * 1000 * FPEP_CLK_MHZ;
endpackage

// file: fpep_props.sv
`timescale 1ns/1ns
module fpep_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Watched inputs
	input wire logic prog_voltage_ok,
	input wire logic wdt_reset,
	input wire logic standby_req,
	input wire logic nmi_req,
	input wire logic irq_mask_bit,
	// Watched outputs
	input wire logic flash_rd_valid,
	input wire logic program_en,
	input wire logic erase_en,
	input wire logic prog_verify_en,
	input wire logic [15:0] block_en,
	input wire logic irq_taken,
	input wire logic int_prot,
	input wire logic ram_hit
);
	// One clock domain, so clock and reset are stated once
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// Hardware protection sources turn the array controls off one cycle later
	chk_vpp_clears: assert property (!prog_voltage_ok |=> !program_en && !erase_en && !prog_verify_en)
		else $error("program, erase or verify left on without voltage");
	chk_standby_clears: assert property (standby_req |=> !program_en && !erase_en && block_en == 16'h0000)
		else $error("standby left an operation enabled");
	chk_wdt_clears: assert property (wdt_reset |=> !int_prot && !program_en)
		else $error("watchdog reset left protection or program on");
	// Interrupt protection is caused by an interrupt and then sticks
	chk_int_cause: assert property ($rose(int_prot) |-> $past(irq_taken))
		else $error("interrupt protection rose with no interrupt");
	chk_int_holds: assert property (int_prot && !wdt_reset |=> int_prot)
		else $error("interrupt protection dropped without reset");
	chk_int_blocks: assert property (int_prot |-> !program_en && !erase_en)
		else $error("program or erase on under interrupt protection");
	// Interrupt acceptance and masking
	chk_nmi_taken: assert property (nmi_req |-> irq_taken)
		else $error("non-maskable interrupt not taken");
	chk_mask_irq: assert property (irq_mask_bit && !nmi_req |-> !irq_taken)
		else $error("masked interrupt taken");
	// No enable without a selected block, no valid read while altering
	chk_block_zero: assert property (block_en == 16'h0000 |-> !program_en && !erase_en)
		else $error("program or erase on with no block enabled");
	chk_rd_invalid: assert property (program_en || erase_en |-> !flash_rd_valid)
		else $error("flash read marked valid while altering");

	// Main scenarios reached
	cov_program: cover property (program_en);
	cov_int_prot: cover property ($rose(int_prot));
	cov_overlap: cover property (ram_hit);
endmodule

bind fpep_top fpep_props fpep_props_inst (.clk_sys, .sys_rst, .prog_voltage_ok, .wdt_reset,
	.standby_req, .nmi_req, .irq_mask_bit, .flash_rd_valid, .program_en, .erase_en,
	.prog_verify_en, .block_en, .irq_taken, .int_prot, .ram_hit);

// file: fpep_top.sv
`timescale 1ns/1ns
module fpep_top
	import fpep_pkg::*;
#(
	parameter int BLOCKS_A = 8,
	parameter int BLOCKS_B = 8
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	// Hardware protection sources and boot strap
	input wire logic prog_voltage_ok,
	input wire logic wdt_reset,
	input wire logic standby_req,
	input wire logic boot_mode,
	// Interrupt sources
	input wire logic nmi_req,
	input wire logic irq_req,
	input wire logic irq_mask_bit,
	// Flash access from the CPU
	input wire logic [15:0] cpu_addr,
	output logic ram_hit,
	output logic [15:0] ram_addr,
	output logic flash_rd_valid,
	// Flash array controls and interrupt state
	output logic program_en,
	output logic erase_en,
	output logic prog_verify_en,
	output logic erase_verify_en,
	output logic prewrite_verify_en,
	output logic [15:0] block_en,
	output logic irq_taken,
	output logic int_prot
);
	fpep_if pif ();

	// Register contents
	logic [7:0] flash_ctrl_reg_q;
	logic [7:0] block_select_reg_a_q;
	logic [7:0] block_select_reg_b_q;
	logic [7:0] wait_config_reg_q;

	// Protection and overlap state
	logic int_prot_q;
	logic ovl_live_q;
	logic boot_q;
	logic boot_pend_q;

	// Register port decode and read path
	logic we_ctrl;
	logic we_sel_a;
	logic we_sel_b;
	logic we_wcfg;
	logic [7:0] reg_rdata_q;
	logic [7:0] status_d;

	// Hardware and interrupt terms
	logic hw_clear;
	logic hw_block;
	logic irq_accept;
	logic busy;

	// Registered array controls
	logic program_en_q;
	logic erase_en_q;
	logic [2:0] verify_en_q;
	logic [15:0] block_en_q;
	logic flash_rd_valid_q;

	// Writable mask of block selects, sized to the blocks present
	function automatic logic [7:0] sel_mask(input int n);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (i < n)
			begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	// Register write hit test
	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs, input logic we);
		return we && (a == ofs);
	endfunction

	// Write strobes per register
	assign we_ctrl = wr_hit(reg_addr, FPEP_OFS_FLASH_CTRL, reg_we);
	assign we_sel_a = wr_hit(reg_addr, FPEP_OFS_BLOCK_SEL_A, reg_we);
	assign we_sel_b = wr_hit(reg_addr, FPEP_OFS_BLOCK_SEL_B, reg_we);
	assign we_wcfg = wr_hit(reg_addr, FPEP_OFS_WAIT_CONFIG, reg_we);

	// Clearing events: lost programming voltage, watchdog reset, standby
	assign hw_clear = ~prog_voltage_ok | wdt_reset | standby_req; // see RULE_06
	assign hw_block = hw_clear; // see RULE_07
	assign busy = flash_ctrl_reg_q[FPEP_FC_PROGRAM] | flash_ctrl_reg_q[FPEP_FC_ERASE];

	// Accepted interrupts; mask leaves only the non-maskable one, boot allows only it
	assign irq_accept = nmi_req | (irq_req & ~irq_mask_bit & ~boot_q); // see RULE_16

	// Flash control register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flash_ctrl_reg_q <= FPEP_RST_FLASH_CTRL; // see RULE_08
		end
		else if (hw_clear)
		begin
			flash_ctrl_reg_q <= FPEP_RST_FLASH_CTRL; // see RULE_07
		end
		else if (we_ctrl)
		begin
			flash_ctrl_reg_q <= {3'h0, reg_wdata[4:0]};
		end
	end

	// Block select register A; held through interrupt protection
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			block_select_reg_a_q <= FPEP_RST_BLOCK_SEL; // see RULE_08
		end
		else if (hw_clear)
		begin
			block_select_reg_a_q <= FPEP_RST_BLOCK_SEL; // see RULE_06
		end
		else if (we_sel_a)
		begin
			block_select_reg_a_q <= reg_wdata & sel_mask(BLOCKS_A);
		end
	end

	// Block select register B; held through interrupt protection
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			block_select_reg_b_q <= FPEP_RST_BLOCK_SEL; // see RULE_08
		end
		else if (hw_clear)
		begin
			block_select_reg_b_q <= FPEP_RST_BLOCK_SEL; // see RULE_06
		end
		else if (we_sel_b)
		begin
			block_select_reg_b_q <= reg_wdata & sel_mask(BLOCKS_B);
		end
	end

	// Boot strap captured on the first edge after reset release
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			boot_pend_q <= 1'b1;
			boot_q <= 1'b0;
		end
		else if (boot_pend_q)
		begin
			boot_pend_q <= 1'b0;
			boot_q <= boot_mode;
		end
	end

	// Wait configuration register holding the overlap selects
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wait_config_reg_q <= FPEP_RST_WAIT_CONFIG;
		end
		else if (wdt_reset)
		begin
			wait_config_reg_q <= FPEP_RST_WAIT_CONFIG;
		end
		else if (we_wcfg)
		begin
			wait_config_reg_q <= reg_wdata;
		end
		else if (boot_pend_q && boot_mode)
		begin
			wait_config_reg_q[FPEP_WC_OVL_HI] <= 1'b1; // see RULE_17
			wait_config_reg_q[FPEP_WC_OVL_LO] <= 1'b1;
		end
	end

	// Interrupt protection latches until a reset
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			int_prot_q <= 1'b0;
		end
		else if (irq_accept && busy && !hw_clear)
		begin
			int_prot_q <= 1'b1; // see RULE_10
		end
		else if (wdt_reset)
		begin
			int_prot_q <= 1'b0; // see RULE_11
		end
	end

	// Overlap goes live when an interrupt arrives with both selects and 12 V
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ovl_live_q <= 1'b0;
		end
		else if (!pif.ovl_hi || !pif.ovl_lo || !prog_voltage_ok)
		begin
			ovl_live_q <= 1'b0;
		end
		else if (irq_accept)
		begin
			ovl_live_q <= 1'b1; // see RULE_13
		end
	end

	// Drive the shared decision and mapping signals
	assign pif.program_req = flash_ctrl_reg_q[FPEP_FC_PROGRAM];
	assign pif.erase_req = flash_ctrl_reg_q[FPEP_FC_ERASE];
	assign pif.verify_req = {flash_ctrl_reg_q[FPEP_FC_PREW_VFY],
		flash_ctrl_reg_q[FPEP_FC_ERASE_VFY], flash_ctrl_reg_q[FPEP_FC_PROG_VFY]};
	assign pif.block_sel = {block_select_reg_b_q, block_select_reg_a_q};
	assign pif.ovl_hi = wait_config_reg_q[FPEP_WC_OVL_HI]; // see RULE_19
	assign pif.ovl_lo = wait_config_reg_q[FPEP_WC_OVL_LO]; // see RULE_19
	assign pif.hw_block = hw_block;
	assign pif.int_prot = int_prot_q | (irq_accept & busy); // see RULE_10

	// Mapping inputs to the overlap decoder
	assign pif.cpu_addr = cpu_addr;
	assign pif.ovl_live = ovl_live_q;

	// Protection decision
	fpep_guard fpep_guard_inst (
		.pi(pif.guard)
	);

	// RAM overlap mapping
	fpep_overlap fpep_overlap_inst (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.oi(pif.ovl)
	);

	// Registered array controls
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			program_en_q <= 1'b0;
			erase_en_q <= 1'b0;
			verify_en_q <= 3'h0;
			block_en_q <= 16'h0000;
		end
		else
		begin
			program_en_q <= pif.program_en; // see RULE_20
			erase_en_q <= pif.erase_en;
			verify_en_q <= pif.verify_en; // see RULE_03
			block_en_q <= pif.block_en; // see RULE_02
		end
	end

	// Read validity flag for vector fetch and other flash reads
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flash_rd_valid_q <= 1'b1;
		end
		else
		begin
			flash_rd_valid_q <= ~(pif.program_req | pif.erase_req) | hw_clear; // see RULE_12
		end
	end

	// Status word showing protection state
	always_comb
	begin
		status_d = 8'h00;
		status_d[FPEP_ST_SW_PROT] = pif.sw_prot; // see RULE_01
		status_d[FPEP_ST_INT_PROT] = int_prot_q;
		status_d[FPEP_ST_VPP_OK] = prog_voltage_ok;
		status_d[FPEP_ST_OVL_LIVE] = ovl_live_q;
		status_d[FPEP_ST_RD_VALID] = flash_rd_valid_q;
		status_d[FPEP_ST_BOOT] = boot_q;
	end

	// Read data one cycle after the read strobe, zero when idle or unmapped
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata_q <= 8'h00;
		end
		else if (reg_re)
		begin
			case (reg_addr)
				FPEP_OFS_FLASH_CTRL: reg_rdata_q <= flash_ctrl_reg_q;
				FPEP_OFS_BLOCK_SEL_A: reg_rdata_q <= block_select_reg_a_q;
				FPEP_OFS_BLOCK_SEL_B: reg_rdata_q <= block_select_reg_b_q;
				FPEP_OFS_WAIT_CONFIG: reg_rdata_q <= wait_config_reg_q;
				FPEP_OFS_STATUS: reg_rdata_q <= status_d;
				default: reg_rdata_q <= 8'h00;
			endcase
		end
		else
		begin
			reg_rdata_q <= 8'h00;
		end
	end

	// Register read data
	assign reg_rdata = reg_rdata_q;

	// Array controls
	assign program_en = program_en_q;
	assign erase_en = erase_en_q;
	assign prog_verify_en = verify_en_q[0];
	assign erase_verify_en = verify_en_q[1];
	assign prewrite_verify_en = verify_en_q[2];
	assign block_en = block_en_q;

	// Read validity, overlap mapping and interrupt state
	assign flash_rd_valid = flash_rd_valid_q;
	assign ram_hit = pif.ram_hit;
	assign ram_addr = pif.ram_addr;
	assign irq_taken = irq_accept; // Combinational accept strobe
	assign int_prot = int_prot_q;
endmodule

// file: fpep_top_test.sv
`timescale 1ns/1ns
module fpep_top_test;
	import fpep_pkg::*;
	// One ordinary case: registers written and enables expected
	typedef struct packed {
		logic [7:0] wcfg;
		logic [7:0] sel_a;
		logic [7:0] sel_b;
		logic [7:0] ctrl;
		logic [4:0] exp_en;
		logic [15:0] exp_blk;
	} fpep_row_s;
	fpep_row_s rows [8] = '{
		'{8'h00, 8'h01, 8'h00, 8'h01, 5'h01, 16'h0001},
		'{8'h00, 8'h00, 8'h80, 8'h02, 5'h02, 16'h8000},
		'{8'h00, 8'h00, 8'h00, 8'h01, 5'h00, 16'h0000},
		'{8'h40, 8'hff, 8'h00, 8'h01, 5'h00, 16'h0000},
		'{8'h80, 8'hff, 8'h00, 8'h02, 5'h00, 16'h0000},
		'{8'hc0, 8'h0f, 8'h00, 8'h01, 5'h01, 16'h000f},
		'{8'h40, 8'h00, 8'h00, 8'h1c, 5'h1c, 16'h0000},
		'{8'h00, 8'h00, 8'h00, 8'h1c, 5'h1c, 16'h0000}};
	// Overlap modes: select bits, CPU address, RAM address
	logic [7:0] ovl_wc [3] = '{8'h40, 8'h80, 8'hc0};
	logic [15:0] ovl_cpu [3] = '{16'h0080, 16'h0100, 16'h0006};
	logic [15:0] ovl_ram [3] = '{16'hf880, 16'hf900, 16'h0000};
	// Design inputs
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'h0, reg_re = 1'h0, prog_voltage_ok = 1'h1, wdt_reset = 1'h0;
	logic standby_req = 1'h0, boot_mode = 1'h0, nmi_req = 1'h0, irq_req = 1'h0;
	logic irq_mask_bit = 1'h0;
	logic [15:0] cpu_addr = 16'h0000;
	// Design outputs
	logic [7:0] reg_rdata;
	logic ram_hit, flash_rd_valid, program_en, erase_en, prog_verify_en, erase_verify_en;
	logic prewrite_verify_en, irq_taken, int_prot;
	logic [15:0] ram_addr, block_en;
	int n_fail = 0, n_compared = 0, cyc = 0;

	fpep_top fpep_top_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
		.reg_rdata, .prog_voltage_ok, .wdt_reset, .standby_req, .boot_mode, .nmi_req,
		.irq_req, .irq_mask_bit, .cpu_addr, .ram_hit, .ram_addr, .flash_rd_valid,
		.program_en, .erase_en, .prog_verify_en, .erase_verify_en, .prewrite_verify_en,
		.block_en, .irq_taken, .int_prot);

	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	task automatic tally_and_finish();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Register port: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_we <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_we <= 1'h0;
	endtask

	task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_re <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_re <= 1'h0;
		#1 check(what, reg_rdata, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic pulse_reset();
		@(posedge clk_sys);
		sys_rst <= 1'h1;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'h0;
	endtask

	initial
	begin
		repeat (10) @(posedge clk_sys);
		check("rd_valid_in_reset", flash_rd_valid, 32'h1);
		sys_rst <= 1'h0;
		rd_chk("ctrl_rst", FPEP_OFS_FLASH_CTRL, 8'h00);
		rd_chk("wcfg_rst", FPEP_OFS_WAIT_CONFIG, 8'h08);
		wr(4'h7, 8'hff);
		rd_chk("unmapped", 4'h7, 8'h00);
		$display("test reset done");
		// Ordinary protection cases
		foreach (rows[i])
		begin
			wr(FPEP_OFS_WAIT_CONFIG, rows[i].wcfg);
			wr(FPEP_OFS_BLOCK_SEL_A, rows[i].sel_a);
			wr(FPEP_OFS_BLOCK_SEL_B, rows[i].sel_b);
			wr(FPEP_OFS_FLASH_CTRL, rows[i].ctrl);
			tick(3);
			check("enables", {prewrite_verify_en, erase_verify_en, prog_verify_en, erase_en,
				program_en}, rows[i].exp_en);
			check("block_en", block_en, rows[i].exp_blk);
		end
		$display("test table done");
		// Voltage loss, watchdog reset and standby in mid-program
		for (int k = 0; k < 3; k++)
		begin
			wr(FPEP_OFS_BLOCK_SEL_A, 8'h01);
			wr(FPEP_OFS_FLASH_CTRL, 8'h01);
			tick(2);
			check("prog_on", program_en, 32'h1);
			check("rd_invalid", flash_rd_valid, 32'h0);
			@(posedge clk_sys);
			prog_voltage_ok <= (k != 0);
			wdt_reset <= (k == 1);
			standby_req <= (k == 2);
			wr(FPEP_OFS_FLASH_CTRL, 8'h1c);
			tick(1);
			check("hw_off", {prog_verify_en, program_en}, 32'h0);
			@(posedge clk_sys);
			prog_voltage_ok <= 1'h1;
			wdt_reset <= 1'h0;
			standby_req <= 1'h0;
			rd_chk("ctrl_cleared", FPEP_OFS_FLASH_CTRL, 8'h00);
			rd_chk("sel_cleared", FPEP_OFS_BLOCK_SEL_A, 8'h00);
			rd_chk("wcfg_kept", FPEP_OFS_WAIT_CONFIG, (k == 0) ? 8'h00 : 8'h08);
		end
		$display("test hardware clear done");
		// Masked request, unmasked request, non-maskable request while programming
		for (int j = 0; j < 3; j++)
		begin
			wr(FPEP_OFS_BLOCK_SEL_A, 8'h01);
			wr(FPEP_OFS_FLASH_CTRL, 8'h01);
			@(posedge clk_sys);
			irq_mask_bit <= (j != 1);
			irq_req <= (j != 2);
			nmi_req <= (j == 2);
			#1 check("irq_taken", irq_taken, j != 0);
			@(posedge clk_sys);
			irq_req <= 1'h0;
			nmi_req <= 1'h0;
			tick(2);
			check("int_prot", {int_prot, program_en}, (j == 0) ? 32'h1 : 32'h2);
			rd_chk("ctrl_kept", FPEP_OFS_FLASH_CTRL, 8'h01);
			wr(FPEP_OFS_FLASH_CTRL, 8'h05);
			tick(2);
			check("verify_kept", {prog_verify_en, program_en}, (j == 0) ? 32'h3 : 32'h2);
			@(posedge clk_sys);
			wdt_reset <= 1'h1;
			@(posedge clk_sys);
			wdt_reset <= 1'h0;
		end
		$display("test interrupt done");
		// Overlap windows, the vector window only after an interrupt
		for (int m = 0; m < 3; m++)
		begin
			wr(FPEP_OFS_WAIT_CONFIG, ovl_wc[m]);
			cpu_addr <= ovl_cpu[m];
			tick(2);
			check("ovl_hit", ram_hit, m != 2);
			if (m != 2)
				check("ovl_addr", ram_addr, ovl_ram[m]);
		end
		@(posedge clk_sys);
		nmi_req <= 1'h1;
		@(posedge clk_sys);
		nmi_req <= 1'h0;
		tick(2);
		check("ovl_live", {ram_hit, ram_addr}, 32'h1f806);
		rd_chk("ovl_bits", FPEP_OFS_WAIT_CONFIG, 8'hc0);
		rd_chk("status_live", FPEP_OFS_STATUS, 8'h1d);
		@(posedge clk_sys);
		cpu_addr <= 16'hf780;
		tick(2);
		check("handler_ram", ram_hit, 32'h0);
		@(posedge clk_sys);
		cpu_addr <= 16'h0006;
		prog_voltage_ok <= 1'h0;
		tick(3);
		check("ovl_drop", ram_hit, 32'h0);
		@(posedge clk_sys);
		prog_voltage_ok <= 1'h1;
		boot_mode <= 1'h1;
		$display("test overlap done");
		// Boot strap sets both overlap bits and takes only the non-maskable request
		pulse_reset();
		rd_chk("boot_wcfg", FPEP_OFS_WAIT_CONFIG, 8'hc8);
		@(posedge clk_sys);
		irq_mask_bit <= 1'h0;
		irq_req <= 1'h1;
		#1 check("boot_irq", irq_taken, 32'h0);
		@(posedge clk_sys);
		nmi_req <= 1'h1;
		#1 check("boot_nmi", irq_taken, 32'h1);
		@(posedge clk_sys);
		irq_req <= 1'h0;
		nmi_req <= 1'h0;
		wr(FPEP_OFS_WAIT_CONFIG, 8'h08);
		rd_chk("boot_user_clear", FPEP_OFS_STATUS, 8'h35);
		$display("test boot done");
		tally_and_finish();
	end
endmodule
